// [hdl/mps_sequencer.sv]
/*
  Micro-program sequencer: opcode register, predecode and secondary
  lookup, flag and feedback selection, next-address sequencing, the
  64-word micro RAM and the ALU instruction / A-address outputs.
  Assumes the micro PROM sits outside, addressed by microAddress, and that
  the ALU board supplies conditions and the predecode disable.
*/
// The placing of the registers and strobed register access were chosen for this implementation.
`timescale 1ns/100ps
`include "mps_regs.svh"
// Overview of operation
// - micro-cycle at least 375 ns; sequencer may hold indefinitely.
// - next address from micro-word feedback, test flags and opcode.
// - load strobe copies secondary and primary buses into address.
// - load strobe forces both buses high, start at row 15 column 15.
// - load strobe raised by clear, bus time-out or parity error.
// - after start, test combined flag, then time-out alone via carry bits.
// - clear path runs standard micro-program, then fetches first opcode.
// - first step uses nine latched bits into predecode, jump-zero-row.
// - predecode supplies low function bits; one code reserved for interrupt.
// - jump-zero-row decode enables interrupt pending check.
// - pending interrupt forces predecode high, entry at address 0.12.
// - next step selects cpu and timer interrupt as low function bits.
// - primary bus takes opcode 4..7 or secondary lookup table.
// - secondary bus jumps on opcode 8..11 or secondary lookup table.
// - flag chosen from six ALU conditions, time-out, I/O pending.
// - A-address selector lives on this board; mask bits pass on.
// - ALU instruction bits mapped from micro-word bits 5,4,1,6,7,0,2,3.
// - fourteen micro-word bits drive addresses, shift and mask.
// - A-address select from micro-word 47,30,29 per table.
// - nine-bit address; micro RAM uses six low bits when executing.
// - latch part usable when loaded, counter part next cycle.
module mps_sequencer (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic microStep,
  input wire logic [15:0] iBus,
  input wire logic opLoad,
  input wire logic cpuClear,
  input wire logic busTimeout,
  input wire logic parityError,
  input wire logic toPeFlag,
  input wire logic timeoutFlag,
  input wire logic [5:0] aluCond,
  input wire logic ioPending,
  input wire logic cpuInt,
  input wire logic timerInt,
  input wire logic predecodeDisable,
  input wire logic ramLoad,
  input wire logic ramSelect,
  input wire logic [`MPS_W-1:0] promWord,
  output logic stepReady,
  output logic [`MPS_ADDR_W-1:0] microAddress,
  output logic [`MPS_W-1:0] microWordBits,
  output logic [7:0] aluInstr,
  output logic [3:0] aluAAddr,
  output logic jumpZeroRowFlag,
  output logic maxMin
);
  // -------------------------------------------------------------------
  // lookup tables
  // -------------------------------------------------------------------
  // instruction class from the nine latched bits; 4'hf never appears
  // for an instruction since it is kept for the interrupt entry
  function automatic logic [3:0] predecodeRom(input logic [8:0] op9);
    logic [3:0] cls;
    cls = op9[8:5] ^ {3'h0, op9[0]};
    predecodeRom = (cls == 4'hf) ? 4'he : cls;
  endfunction

  // four tables selected by micro-word 15,14 over opcode 8..13 and 3
  function automatic logic [3:0] secondaryLookupRom(input logic [1:0] tbl,
      input logic [6:0] idx);
    logic [3:0] v;
    case (tbl)
      2'h0: v = idx[6:3];
      2'h1: v = idx[3:0];
      2'h2: v = {idx[0], idx[6:4]};
      default: v = ~idx[4:1];
    endcase
    secondaryLookupRom = v;
  endfunction

  // -------------------------------------------------------------------
  // state
  // -------------------------------------------------------------------
  mps_pkg::mps_state_t st_reg;
  mps_pkg::mps_state_t st_next;
  logic [`MPS_W-1:0] microRam [`MPS_RAM_DEPTH];

  // -------------------------------------------------------------------
  // opcode register views
  // -------------------------------------------------------------------
  logic [8:0] opLatchView;
  logic [15:0] op;
  logic [15:0] ibusSwapped;
  logic [`MPS_W-1:0] mw;
  // the bus is byte-swapped into the opcode register
  assign ibusSwapped = {iBus[7:0], iBus[15:8]};
  // latch part is transparent while loading; counter waits a cycle
  assign opLatchView = opLoad ? ibusSwapped[15:7] : st_reg.opLatch;
  assign op = {opLatchView[8:1], st_reg.opCnt};
  assign mw = st_reg.uword;

  // -------------------------------------------------------------------
  // instruction buses, flag and function code
  // -------------------------------------------------------------------
  logic seqLoadStrobe;
  logic [3:0] pxpOut;
  logic [3:0] primaryInstrBus;
  logic [3:0] secondaryInstrBus;
  logic [3:0] predecodeOut;
  logic flagIn;
  logic [2:0] flagSel;
  logic [3:0] fbGroup;
  logic [3:0] fnLow;
  mps_pkg::mps_fn_t fnHigh;

  assign seqLoadStrobe = cpuClear | busTimeout | parityError;
  assign pxpOut = secondaryLookupRom({mw[`MPS_FB15], mw[`MPS_FB14]},
    {op[13:8], op[3]});

  // bus selectors; the load strobe forces both buses high
  always_comb begin
    if (seqLoadStrobe) begin
      primaryInstrBus = `MPS_RESET_NIB;
      secondaryInstrBus = `MPS_RESET_NIB;
    end else begin
      primaryInstrBus = mw[`MPS_FB24] ? pxpOut : op[7:4];
      secondaryInstrBus = mw[`MPS_FB25] ? pxpOut : op[11:8];
    end
  end

  // pending interrupt overrides the class decode
  assign predecodeOut = predecodeDisable ? 4'hf
    : predecodeRom(opLatchView);

  // eight flag sources; carry/page bits narrow the error test
  assign flagSel = mw[`MPS_FS3:`MPS_FS1];
  always_comb begin
    case (flagSel)
      3'h6: begin
        if (mw[`MPS_CPS_HI:`MPS_CPS_LO] == `MPS_CPS_TO_ONLY) begin
          flagIn = timeoutFlag;
        end else begin
          flagIn = toPeFlag;
        end
      end
      3'h7: flagIn = ioPending;
      default: flagIn = aluCond[flagSel];
    endcase
  end

  // upper function bits come straight from the micro word
  assign fnHigh = mps_pkg::mps_fn_t'({mw[`MPS_AC6], mw[`MPS_AC5],
    mw[`MPS_AC4]});
  assign jumpZeroRowFlag = (fnHigh == mps_pkg::FN_ZROW);
  assign fbGroup = {mw[`MPS_FS3:`MPS_FS1], mw[`MPS_FS0]};

  // low function bits: feedback selectors
  always_comb begin
    if (fnHigh == mps_pkg::FN_ZROW) begin
      // two low bits are inverted, so all-ones gives column 12
      fnLow = {predecodeOut[3:2], ~predecodeOut[1:0]};
    end else if (mw[`MPS_FB_DIRECT] && !mw[`MPS_FB_MODE]) begin
      fnLow = {mw[`MPS_FB15], mw[`MPS_FB14], 2'h0};
    end else if (mw[`MPS_FB_DIRECT]) begin
      fnLow = 4'h8;
    end else if (fbGroup == `MPS_GRP_INT) begin
      fnLow = {mw[`MPS_FB15], mw[`MPS_FB14], timerInt, cpuInt};
    end else if (fbGroup == `MPS_GRP_PRE) begin
      fnLow = {mw[`MPS_FB15], mw[`MPS_FB14], ~predecodeOut[1:0]};
    end else begin
      fnLow = {mw[`MPS_FB15], mw[`MPS_FB14], mw[`MPS_FB25],
        mw[`MPS_FB24]};
    end
  end

  // -------------------------------------------------------------------
  // next micro-address
  // -------------------------------------------------------------------
  logic [`MPS_ADDR_W-1:0] nextAddr;
  logic [4:0] curRow;
  logic [3:0] curCol;
  assign curRow = st_reg.addr[`MPS_ADDR_W-1:`MPS_ROW_LSB];
  assign curCol = st_reg.addr[`MPS_ROW_LSB-1:0];

  // row/column jumps in the manner of a classic control unit
  always_comb begin
    case (fnHigh)
      mps_pkg::FN_ZROW: nextAddr = {`MPS_ROW_ZERO, fnLow};
      mps_pkg::FN_JCR: nextAddr = {curRow, fnLow};
      mps_pkg::FN_JCC: nextAddr = {1'b0, fnLow, curCol};
      mps_pkg::FN_JPX: nextAddr = {1'b0, fnLow, primaryInstrBus};
      mps_pkg::FN_JSX: nextAddr = {1'b0, fnLow, secondaryInstrBus};
      mps_pkg::FN_JFL: nextAddr = {curRow, fnLow[3:1], flagIn};
      mps_pkg::FN_JRF: nextAddr = {1'b0, fnLow[3:1], flagIn, curCol};
      default: nextAddr = st_reg.addr;
    endcase
  end

  // -------------------------------------------------------------------
  // micro memory source
  // -------------------------------------------------------------------
  logic [`MPS_W-1:0] fetchWord;
  // RAM executes on the six low bits only
  assign fetchWord = ramSelect
    ? microRam[st_reg.addr[`MPS_RAM_AW-1:0]] : promWord;
  logic ramWrite;
  assign ramWrite = ramLoad && (st_reg.ramPart == 2'h2);

  // RAM is loaded at the six low opcode bits; the outside PROM holds the
  // standard program including the clear sequence
  always_ff @(posedge ref_clk) begin
    if (ramWrite) begin
      microRam[op[`MPS_RAM_AW-1:0]] <= {iBus, st_reg.ramAsm};
    end
  end

  // -------------------------------------------------------------------
  // sequencing
  // -------------------------------------------------------------------
  logic stepTaken;
  assign stepReady = (st_reg.phase == mps_pkg::PH_IDLE)
    && (st_reg.cnt == 3'h0);
  // a step arriving too early is ignored, which keeps the cycle long
  assign stepTaken = microStep && stepReady;

  always_comb begin
    st_next = st_reg;
    if (st_reg.cnt != 3'h0) begin
      st_next.cnt = st_reg.cnt - 3'h1;
    end
    case (st_reg.phase)
      mps_pkg::PH_IDLE: begin
        if (seqLoadStrobe) begin
          // start entry at row 15 column 15
          st_next.addr = {1'b0, secondaryInstrBus, primaryInstrBus};
          st_next.phase = mps_pkg::PH_FETCH;
          st_next.cnt = 3'(`MPS_MIN_CYC - 1);
        end else if (stepTaken) begin
          st_next.addr = nextAddr;
          st_next.phase = mps_pkg::PH_FETCH;
          st_next.cnt = 3'(`MPS_MIN_CYC - 1);
        end
      end
      mps_pkg::PH_FETCH: begin
        st_next.uword = fetchWord;
        st_next.phase = mps_pkg::PH_IDLE;
      end
      default: st_next.phase = mps_pkg::PH_IDLE;
    endcase
    // opcode register: latch and counter byte; only its low four bits count
    if (opLoad) begin
      st_next.opLatch = ibusSwapped[15:7];
      st_next.opCnt = ibusSwapped[7:0];
    end else if (stepTaken && mw[`MPS_CNT_UP]) begin
      st_next.opCnt[3:0] = st_reg.opCnt[3:0] + 4'h1;
    end else if (stepTaken && mw[`MPS_CNT_DN]) begin
      st_next.opCnt[3:0] = st_reg.opCnt[3:0] - 4'h1;
    end
    // three bus words make one RAM word, low word first
    if (ramLoad) begin
      case (st_reg.ramPart)
        2'h0: st_next.ramAsm[15:0] = iBus;
        2'h1: st_next.ramAsm[31:16] = iBus;
        default: st_next.ramAsm = st_reg.ramAsm;
      endcase
      st_next.ramPart = (st_reg.ramPart == 2'h2) ? 2'h0
        : st_reg.ramPart + 2'h1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      st_reg <= '0;
      st_reg.phase <= mps_pkg::PH_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  // -------------------------------------------------------------------
  // outputs toward the ALU board
  // -------------------------------------------------------------------
  assign microAddress = st_reg.addr;
  assign microWordBits = mw;
  assign maxMin = (st_reg.opCnt[3:0] == 4'h0)
    || (st_reg.opCnt[3:0] == 4'hf);
  // ALU bits 10..17 in that order
  assign aluInstr = {mw[5], mw[4], mw[1], mw[6], mw[7], mw[0], mw[2],
    mw[3]};

  // A-address selector; mask and shift bits pass on in microWordBits
  always_comb begin
    case ({mw[`MPS_ASEL2], mw[`MPS_ASEL1], mw[`MPS_ASEL0]})
      3'h0: aluAAddr = {mw[26], mw[27], mw[31], mw[28]};
      3'h1: aluAAddr = {1'b0, op[10:8]};
      3'h2: aluAAddr = {2'h1, op[7:6]};
      3'h7: aluAAddr = {1'b0, op[2:0]};
      default: aluAAddr = 4'h0;
    endcase
  end

  // -------------------------------------------------------------------
  // checks
  // -------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  chk_step_spacing: assert property (
    stepTaken |=> !stepReady [*3] ##1 stepReady)
    else $error("step accepted before minimum cycle");
  chk_start_entry: assert property (
    seqLoadStrobe && st_reg.phase == mps_pkg::PH_IDLE
      |=> microAddress == 9'h0ff)
    else $error("start entry not at row 15 column 15");
  chk_bus_forced: assert property (
    seqLoadStrobe |-> primaryInstrBus == 4'hf
      && secondaryInstrBus == 4'hf)
    else $error("instruction buses not forced on load");
  chk_load_cause: assert property (
    (cpuClear || busTimeout || parityError) == seqLoadStrobe)
    else $error("load strobe cause mismatch");
  chk_irq_entry: assert property (
    stepTaken && !seqLoadStrobe && jumpZeroRowFlag && predecodeDisable
      |=> microAddress == 9'h00c)
    else $error("interrupt entry not at 0.12");
  chk_irq_source: assert property (
    fnHigh != mps_pkg::FN_ZROW && !mw[`MPS_FB_DIRECT]
      && fbGroup == `MPS_GRP_INT |-> fnLow[1:0] == {timerInt, cpuInt})
    else $error("interrupt sources not on low function bits");
  chk_alu_map: assert property (
    aluInstr[7] == mw[5] && aluInstr[2] == mw[0] && aluInstr[0] == mw[3])
    else $error("ALU instruction bit mapping wrong");
  chk_aaddr_zero: assert property (
    mw[`MPS_ASEL2] && !(mw[`MPS_ASEL1] && mw[`MPS_ASEL0])
      |-> aluAAddr == 4'h0)
    else $error("unlisted A-select not zero");
  chk_fetch_word: assert property (
    st_reg.phase == mps_pkg::PH_FETCH && !ramSelect
      |=> mw == $past(promWord))
    else $error("fetched word not taken from memory");
  chk_counter_late: assert property (
    opLoad |=> st_reg.opCnt == $past(ibusSwapped[7:0]))
    else $error("counter part not loaded");

  // instruction entry: row zero, and never the interrupt column
  chk_zero_row: assert property (
    stepTaken && !seqLoadStrobe && jumpZeroRowFlag
      |=> curRow == `MPS_ROW_ZERO)
    else $error("instruction entry not in row zero");
  chk_class_entry: assert property (
    stepTaken && !seqLoadStrobe && jumpZeroRowFlag && !predecodeDisable
      |=> microAddress != 9'h00c)
    else $error("instruction class reached interrupt entry");
  // a flag jump lands on the even or odd column chosen by the flag
  chk_flag_jump: assert property (
    stepTaken && !seqLoadStrobe && fnHigh == mps_pkg::FN_JFL
      |=> microAddress[0] == $past(flagIn))
    else $error("flag jump ignored the selected flag");
  chk_io_flag: assert property (
    flagSel == 3'h7 |-> flagIn == ioPending)
    else $error("I/O pending not on flag source seven");
  // low counter steps once per taken step with a count bit set, unless the register is loaded
  chk_counter_step: assert property (
    stepTaken && !opLoad && mw[`MPS_CNT_UP]
      |=> st_reg.opCnt[3:0] == $past(st_reg.opCnt[3:0]) + 4'h1)
    else $error("opcode counter did not count up");

  // the fetch cycle and minimum spacing sit between load and first step
  cov_start: cover property (seqLoadStrobe ##[3:8] stepTaken);
  cov_flag: cover property (stepTaken && fnHigh == mps_pkg::FN_JFL);
  cov_irq: cover property (stepTaken && jumpZeroRowFlag
    && predecodeDisable);
  cov_ram: cover property (ramWrite);
  cov_jsx: cover property (stepTaken && fnHigh == mps_pkg::FN_JSX);
endmodule

// [hdl/mps_regs.svh]
/*
  Constants of the micro-program sequencer: field positions in the micro
  word, address layout, carry/page and feedback group codes and micro-cycle timing.
  Assumes inclusion by bare name from the sequencer package and module.
*/
`ifndef MPS_REGS_SVH
`define MPS_REGS_SVH
// -------------------------------------------------------------------
// timing
// -------------------------------------------------------------------
`define MPS_CLK_NS 100
`define MPS_MIN_CYCLE_NS 375
`define MPS_MIN_CYC ((`MPS_MIN_CYCLE_NS + `MPS_CLK_NS - 1) / `MPS_CLK_NS)
// -------------------------------------------------------------------
// address layout: row in the upper five bits, column in the lower four
// -------------------------------------------------------------------
`define MPS_ADDR_W 9
`define MPS_ROW_LSB 4
`define MPS_RESET_NIB 4'hf
`define MPS_RAM_DEPTH 64
`define MPS_RAM_AW 6
`define MPS_ROW_ZERO 5'h00
// -------------------------------------------------------------------
// micro-word fields
// -------------------------------------------------------------------
`define MPS_W 48
`define MPS_FB_DIRECT 8
`define MPS_FS0 9
`define MPS_FB_MODE 10
`define MPS_FS1 11
`define MPS_FS3 13
`define MPS_FB14 14
`define MPS_FB15 15
`define MPS_CPS_LO 21
`define MPS_CPS_HI 23
`define MPS_FB24 24
`define MPS_FB25 25
`define MPS_CNT_UP 32
`define MPS_CNT_DN 33
`define MPS_AC5 37
`define MPS_AC6 38
`define MPS_AC4 39
`define MPS_ASEL2 47
`define MPS_ASEL1 30
`define MPS_ASEL0 29
// carry/page code that narrows the test to time-out alone
`define MPS_CPS_TO_ONLY 3'h5
// feedback group that carries the interrupt sources
`define MPS_GRP_INT 4'h2
`define MPS_GRP_PRE 4'h0
`endif

// [hdl/mps_pkg.sv]
/*
  Types of the micro-program sequencer: sequencing functions, phase
  states and the packed state record.
  Assumes the constants header is on the include path.
*/
`include "mps_regs.svh"
package mps_pkg;
  // upper function bits {AC6,AC5,AC4}
  typedef enum logic [2:0] {
    FN_ZROW = 3'h0, FN_JCR = 3'h1, FN_JCC = 3'h2, FN_JPX = 3'h3,
    FN_JSX = 3'h4, FN_JFL = 3'h5, FN_JRF = 3'h6, FN_HOLD = 3'h7
  } mps_fn_t;
  typedef enum logic [1:0] {
    PH_IDLE = 2'h1, PH_FETCH = 2'h2
  } mps_phase_t;
  typedef struct packed {
    logic [`MPS_ADDR_W-1:0] addr;
    logic [`MPS_W-1:0] uword;
    logic [8:0] opLatch;
    logic [7:0] opCnt;
    mps_phase_t phase;
    logic [2:0] cnt;
    logic [31:0] ramAsm;
    logic [1:0] ramPart;
  } mps_state_t;
endpackage

// [sim/mps_alu_model.sv]
/*
  Behavioural far side of the sequencer: the micro PROM contents and the
  arithmetic board's interrupt enable, flag sources and conditions.
  Assumes the bench writes PROM words by hierarchy before it fetches them.
*/
`timescale 1ns/100ps
module mps_alu_model (
  input wire logic [8:0] microAddress,
  input wire logic jumpZeroRowFlag,
  input wire logic intWaiting,
  output logic [47:0] promWord,
  output logic predecodeDisable,
  output logic [5:0] aluCond,
  output logic ioPending
);
  // ------------------------------------------------------------------
  // micro PROM
  // ------------------------------------------------------------------
  logic [47:0] prom [0:511];

  // unwritten words hold, so a stray step cannot run off through memory
  initial begin
    for (int i = 0; i < 512; i++) begin
      prom[i] = 48'h00e0_0000_0000;
    end
  end

  // combinational read, as the sequencer expects
  assign promWord = prom[microAddress];

  // ------------------------------------------------------------------
  // arithmetic board side
  // ------------------------------------------------------------------
  // interrupt check is only enabled in the jump-zero-row step
  assign predecodeDisable = jumpZeroRowFlag & intWaiting;
  // static conditions; no scenario changes them, t_count jumps on them
  assign aluCond = 6'h15;
  assign ioPending = 1'b0;
endmodule

// [sim/tb_top.sv]
/*
  Self-checking bench of the micro-program sequencer: start entry,
  interrupt entry, flag tests, A-address and ALU bit mapping, micro RAM.
  Assumes the far side model and the sequencer's package and header.
*/
`timescale 1ns/100ps
module tb_top;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic microStep = 1'b0;
  logic [15:0] iBus = 16'h0000;
  logic opLoad = 1'b0;
  logic [2:0] cause = 3'h0;
  logic toPeFlag = 1'b0;
  logic timeoutFlag = 1'b0;
  logic cpuInt = 1'b0;
  logic timerInt = 1'b0;
  logic intWaiting = 1'b0;
  logic ramLoad = 1'b0;
  logic ramSelect = 1'b0;
  logic [15:0] op = 16'h0000;
  logic stepReady, jumpZeroRowFlag, maxMin, predecodeDisable, ioPending;
  logic [8:0] microAddress;
  logic [47:0] microWordBits, promWord;
  logic [7:0] aluInstr;
  logic [3:0] aluAAddr;
  logic [5:0] aluCond;
  int err_count = 0;
  int n_checks = 0;

  // ------------------------------------------------------------------
  // clock, instances
  // ------------------------------------------------------------------
  always #50 ref_clk = ~ref_clk;

  mps_sequencer DUT (.ref_clk(ref_clk), .srst(srst), .microStep(microStep),
    .iBus(iBus), .opLoad(opLoad), .cpuClear(cause[0]),
    .busTimeout(cause[1]), .parityError(cause[2]), .toPeFlag(toPeFlag),
    .timeoutFlag(timeoutFlag), .aluCond(aluCond), .ioPending(ioPending),
    .cpuInt(cpuInt), .timerInt(timerInt),
    .predecodeDisable(predecodeDisable), .ramLoad(ramLoad),
    .ramSelect(ramSelect), .promWord(promWord), .stepReady(stepReady),
    .microAddress(microAddress), .microWordBits(microWordBits),
    .aluInstr(aluInstr), .aluAAddr(aluAAddr),
    .jumpZeroRowFlag(jumpZeroRowFlag), .maxMin(maxMin));

  mps_alu_model u_alu (.microAddress(microAddress),
    .jumpZeroRowFlag(jumpZeroRowFlag), .intWaiting(intWaiting),
    .promWord(promWord), .predecodeDisable(predecodeDisable),
    .aluCond(aluCond), .ioPending(ioPending));

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  task finish_test;
    if (err_count == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task chk_val(input logic [47:0] got, input logic [47:0] exp,
               input string msg);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  function logic [7:0] alu_map(input logic [47:0] w);
    return {w[5], w[4], w[1], w[6], w[7], w[0], w[2], w[3]};
  endfunction

  // unlisted select codes give zero, first 111 row wins
  function logic [3:0] a_sel(input logic [47:0] w);
    case ({w[47], w[30], w[29]})
      3'h0: return {w[26], w[27], w[31], w[28]};
      3'h1: return {1'b0, op[10:8]};
      3'h2: return {2'b01, op[7:6]};
      3'h7: return {1'b0, op[2:0]};
      default: return 4'h0;
    endcase
  endfunction

  task chk_word(input logic [47:0] w);
    chk_val(microWordBits, w, "micro word");
    chk_val(48'(aluInstr), 48'(alu_map(w)), "alu instr");
    chk_val(48'(aluAAddr), 48'(a_sel(w)), "a address");
  endtask

  // bounded wait, the minimum cycle may hold the sequencer for a while
  task wait_ready;
    int n;
    n = 0;
    while (stepReady !== 1'b1 && n < 20) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    chk_val(48'(stepReady), 48'h1, "ready");
  endtask

  // byte swapped: low bus byte lands in the upper opcode byte
  task load_op(input logic [15:0] b);
    @(posedge ref_clk);
    iBus <= b;
    opLoad <= 1'b1;
    @(posedge ref_clk);
    opLoad <= 1'b0;
    op = {b[7:0], b[15:8]};
    @(posedge ref_clk);
  endtask

  // load strobe held two cycles; start word follows one edge later
  task do_load(input int c, input logic [47:0] w);
    wait_ready();
    @(posedge ref_clk);
    cause[c] <= 1'b1;
    @(posedge ref_clk);
    #1;
    chk_val(48'(microAddress), 48'h0ff, "start address");
    @(posedge ref_clk);
    cause[c] <= 1'b0;
    #1;
    chk_word(w);
  endtask

  // step held high two more edges: those must both be refused
  task do_step(input logic [8:0] a, input logic [47:0] w);
    wait_ready();
    @(posedge ref_clk);
    microStep <= 1'b1;
    @(posedge ref_clk);
    #1;
    chk_val(48'(microAddress), 48'(a), "next address");
    @(posedge ref_clk);
    #1;
    chk_word(w);
    chk_val(48'(stepReady), 48'h0, "busy");
    @(posedge ref_clk);
    microStep <= 1'b0;
    #1;
    chk_val(48'(microAddress), 48'(a), "refused step");
    @(posedge ref_clk);
    #1;
    chk_val(48'(stepReady), 48'h1, "ready again");
  endtask

  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task t_reset;
    chk_val(48'(microAddress), 48'h0, "reset address");
    chk_val(microWordBits, 48'h0, "reset word");
    chk_val(48'(jumpZeroRowFlag), 48'h1, "reset zero row fn");
    chk_val(48'(stepReady), 48'h1, "reset ready");
  endtask

  // every A-select code, the three load causes in turn
  task t_asel;
    logic [47:0] w;
    load_op(16'h5a3c);
    for (int i = 0; i < 8; i++) begin
      w = 48'h0000_0000_c000;
      w[7:0] = 8'(i * 37 + 91);
      {w[47], w[30], w[29]} = 3'(i);
      {w[31], w[28:26]} = 4'(i + 5);
      u_alu.prom[9'h0ff] = w;
      do_load(i % 3, w);
    end
  endtask

  // interrupt entry at 0.12, then cpu and timer sources resolved
  task t_irq;
    u_alu.prom[9'h0ff] = 48'h0000_0000_c000;
    u_alu.prom[9'h00c] = 48'h0080_0000_c800;
    for (int k = 0; k < 2; k++) begin
      @(posedge ref_clk);
      cpuInt <= (k == 0);
      timerInt <= (k == 1);
      intWaiting <= 1'b1;
      do_load(k, 48'h0000_0000_c000);
      chk_val(48'(jumpZeroRowFlag), 48'h1, "zero row flag");
      do_step(9'h00c, 48'h0080_0000_c800);
      do_step(9'(13 + k), 48'h00e0_0000_0000);
    end
    @(posedge ref_clk);
    intWaiting <= 1'b0;
  endtask

  // combined flag first, then time-out alone through the carry code
  task t_flag;
    u_alu.prom[9'h0ff] = 48'h00c0_0000_7000;
    u_alu.prom[9'h0f4] = 48'h00c0_02a0_7000;
    @(posedge ref_clk);
    toPeFlag <= 1'b0;
    timeoutFlag <= 1'b1;
    do_load(1, 48'h00c0_0000_7000);
    do_step(9'h0f4, 48'h00c0_02a0_7000);
    do_step(9'h0f7, 48'h00e0_0000_0000);
    @(posedge ref_clk);
    toPeFlag <= 1'b1;
    timeoutFlag <= 1'b0;
    do_load(2, 48'h00c0_0000_7000);
    do_step(9'h0f5, 48'h00e0_0000_0000);
  endtask

  // counters and maxMin, ALU and I/O flag sources, plain class entry
  task t_count;
    u_alu.prom[9'h0ff] = 48'h00c1_0000_1000;
    u_alu.prom[9'h0f1] = 48'h00c2_0000_3800;
    u_alu.prom[9'h0f0] = 48'h0;
    load_op(16'h0e00);
    #1;
    chk_val(48'(maxMin), 48'h0, "max/min low");
    do_load(0, 48'h00c1_0000_1000);
    do_step(9'h0f1, 48'h00c2_0000_3800);
    chk_val(48'(maxMin), 48'h1, "counter up");
    do_step(9'h0f0, 48'h0);
    chk_val(48'(maxMin), 48'h0, "counter down");
    wait_ready();
    @(posedge ref_clk);
    microStep <= 1'b1;
    @(posedge ref_clk);
    microStep <= 1'b0;
    #1;
    chk_val(48'(microAddress[8:4]), 48'h0, "zero row");
    chk_val(48'(microAddress == 9'h00c), 48'h0, "class entry");
  endtask

  // three bus transfers make one RAM word at opcode bits 5..0
  task t_ram;
    logic [47:0] rw;
    rw = 48'h9abc_5678_1234;
    load_op(16'h3f5a);
    for (int p = 0; p < 3; p++) begin
      @(posedge ref_clk);
      ramLoad <= 1'b1;
      iBus <= rw[16*p +: 16];
    end
    @(posedge ref_clk);
    ramLoad <= 1'b0;
    ramSelect <= 1'b1;
    do_load(0, rw);
    @(posedge ref_clk);
    ramSelect <= 1'b0;
  endtask

  // ------------------------------------------------------------------
  // main sequence and watchdog
  // ------------------------------------------------------------------
  initial begin
    repeat (4) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    #1;
    t_reset();
    t_asel();
    t_irq();
    t_flag();
    t_count();
    t_ram();
    finish_test();
  end

  // the scenarios need under two hundred cycles; this is ample margin
  initial begin
    repeat (5000) @(posedge ref_clk);
    err_count++;
    finish_test();
  end
endmodule
